// >>> jsg_params.sv
`timescale 1ns/1ns
`include "jsg_defines.svh"
module jsg_params
#(
   parameter bit STEPPER = 1'b0,
   parameter bit SMALL   = 1'b0
)
(
   // Clock, reset, enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // AXI4-Lite write
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Motion loop status
   input  wire logic        jog_active,
   input  wire logic        jog_tick,
   input  wire logic        jog_dir,
   input  wire logic [31:0] pos_error,
   input  wire logic [15:0] pos_p_gain,
   input  wire logic [15:0] pos_i_gain,
   // Parameters to the motion loop
   output logic [15:0]      jog_accel,
   output logic [15:0]      jog_decel,
   output logic [15:0]      jog_speed,
   output logic             jog_mode_vel,
   output logic             torque_sel,
   output logic [15:0]      loop_filter,
   output logic [15:0]      deriv_gain,
   output logic [15:0]      deriv_filter,
   output logic [15:0]      vff_gain,
   output logic [15:0]      vfb_gain,
   output logic [15:0]      loop_p_gain,
   output logic [15:0]      loop_i_gain,
   output logic             jog_fault,
   output logic [31:0]      target_pos
);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   jsg_pkg::jsg_word_t accel_reg, decel_reg, speed_reg, lfilt_reg;
   jsg_pkg::jsg_word_t dgain_reg, dfilt_reg, vff_reg, vfb_reg;
   jsg_pkg::jsg_word_t pflim_reg, vel_i_reg, vel_p_reg;
   jsg_pkg::jsg_mode_e mode_reg;
   logic               trq_reg;
   logic               rej_reg;
   logic               fault_reg;
   logic [31:0]        target_reg;
   logic               awready_reg, wready_reg, bvalid_reg;
   logic               arready_reg, rvalid_reg;
   logic [1:0]         bresp_reg, rresp_reg;
   logic [7:0]         aw_addr_reg;
   logic [31:0]        w_data_reg, rdata_reg;
   logic [3:0]         w_strb_reg;
   logic               wr_fire, wr_ok, wr_hit, mode_ign;
   logic [15:0]        wv;
   logic [31:0]        err_mag;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Inclusive range test
   function automatic logic in_rng(input logic [31:0] v,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
      in_rng = (v <= {16'h0000, hi}) && (v >= {16'h0000, lo});
   endfunction

   // ------------------------------------------------------------
   // Write acceptance
   // ------------------------------------------------------------
   assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg && ce;
   assign wv      = w_data_reg[15:0];
   assign mode_ign = STEPPER && (w_data_reg[1:0] == 2'h2);

   // Range and interlock check of the pending write
   always_comb
   begin
      wr_ok = 1'b0;
      unique case (aw_addr_reg)
         `JSG_OFS_ACCEL, `JSG_OFS_DECEL:
            wr_ok = in_rng(w_data_reg, `JSG_RATE_MIN, `JSG_RATE_MAX)
                    && !jog_active;
         `JSG_OFS_MODE:
            wr_ok = (w_data_reg[1:0] == 2'h1) || (w_data_reg[1:0] == 2'h2);
         `JSG_OFS_SPEED:
            wr_ok = in_rng(w_data_reg, `JSG_SPD_MIN,
                           SMALL ? `JSG_SPD_MAX_SMALL : `JSG_SPD_MAX);
         `JSG_OFS_LFILT, `JSG_OFS_DGAIN, `JSG_OFS_DFILT, `JSG_OFS_VFF,
         `JSG_OFS_VFB, `JSG_OFS_PFLIM, `JSG_OFS_VIGAIN, `JSG_OFS_VPGAIN:
            wr_ok = in_rng(w_data_reg, 16'h0000, `JSG_INT_MAX);
         `JSG_OFS_STATUS:
            wr_ok = 1'b1;
         default:
            wr_ok = 1'b0;
      endcase
      wr_ok  = wr_ok && (w_strb_reg == 4'hF);
      wr_hit = wr_fire && wr_ok;
   end

   // ------------------------------------------------------------
   // AXI write channels
   // ------------------------------------------------------------
   // Address holding
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_reg <= 1'b1;
         aw_addr_reg <= 8'h00;
      end
      else if (ce)
      begin
         if (awvalid && awready_reg)
         begin
            awready_reg <= 1'b0;
            aw_addr_reg <= awaddr;
         end
         else if (wr_fire)
            awready_reg <= 1'b1;
      end
   end

   // Data holding
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wready_reg <= 1'b1;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end
      else if (ce)
      begin
         if (wvalid && wready_reg)
         begin
            wready_reg <= 1'b0;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
         end
         else if (wr_fire)
            wready_reg <= 1'b1;
      end
   end

   // Write response; rejected writes answer SLVERR
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= jsg_pkg::JSG_RESP_OKAY;
      end
      else if (ce)
      begin
         if (wr_fire)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_ok ? jsg_pkg::JSG_RESP_OKAY
                                : jsg_pkg::JSG_RESP_SLVERR;
         end
         else if (bready)
            bvalid_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Parameter storage
   // ------------------------------------------------------------
   // one write at a time, in arrival order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         accel_reg <= `JSG_RST_RATE;
         decel_reg <= `JSG_RST_RATE;
         speed_reg <= `JSG_RST_SPEED;
      end
      else if (wr_hit)
      begin
         if (aw_addr_reg == `JSG_OFS_ACCEL)
         begin
            accel_reg <= wv;
            decel_reg <= wv;
         end
         if (aw_addr_reg == `JSG_OFS_DECEL)
            decel_reg <= wv;
         if (aw_addr_reg == `JSG_OFS_SPEED)
            speed_reg <= wv;
      end
   end

   // Jog mode and torque selection
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_reg <= jsg_pkg::JSG_MODE_POS;
         trq_reg  <= 1'b0;
      end
      else if (wr_hit && aw_addr_reg == `JSG_OFS_MODE && !mode_ign)
      begin
         mode_reg <= jsg_pkg::jsg_mode_e'(w_data_reg[1:0]);
         trq_reg  <= w_data_reg[`JSG_MODE_TRQ_BIT];
      end
   end

   // Servo gains and filters
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         lfilt_reg <= `JSG_RST_GAIN;
         dgain_reg <= `JSG_RST_GAIN;
         dfilt_reg <= `JSG_RST_GAIN;
         vff_reg   <= `JSG_RST_GAIN;
         vfb_reg   <= `JSG_RST_GAIN;
         pflim_reg <= `JSG_RST_GAIN;
         vel_i_reg <= `JSG_RST_GAIN;
         vel_p_reg <= `JSG_RST_GAIN;
      end
      else if (wr_hit)
      begin
         unique case (aw_addr_reg)
            `JSG_OFS_LFILT:  lfilt_reg <= wv;
            `JSG_OFS_DGAIN:  dgain_reg <= wv;
            `JSG_OFS_DFILT:  dfilt_reg <= wv;
            `JSG_OFS_VFF:    vff_reg   <= wv;
            `JSG_OFS_VFB:    vfb_reg   <= wv;
            `JSG_OFS_PFLIM:  pflim_reg <= wv;
            `JSG_OFS_VIGAIN: vel_i_reg <= wv;
            `JSG_OFS_VPGAIN: vel_p_reg <= wv;
            default:         ;
         endcase
      end
   end

   // Sticky rejection flag; a new rejection beats the clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rej_reg <= 1'b0;
      else if (wr_fire && !wr_ok)
         rej_reg <= 1'b1;
      else if (wr_hit && aw_addr_reg == `JSG_OFS_STATUS
               && w_data_reg[`JSG_ST_REJ_BIT])
         rej_reg <= 1'b0;
   end

   // ------------------------------------------------------------
   // Jog behaviour
   // ------------------------------------------------------------
   assign err_mag = pos_error[31] ? (32'h0000_0000 - pos_error) : pos_error;

   // fault only in servo position jog
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         fault_reg <= 1'b0;
      else if (ce)
         fault_reg <= !STEPPER && jog_active
                      && mode_reg == jsg_pkg::JSG_MODE_POS
                      && err_mag > {16'h0000, pflim_reg};
   end

   // target moves by jog speed per tick
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         target_reg <= 32'h0000_0000;
      else if (ce && jog_active && jog_tick
               && mode_reg == jsg_pkg::JSG_MODE_POS)
         target_reg <= jog_dir ? target_reg - {16'h0000, speed_reg}
                               : target_reg + {16'h0000, speed_reg};
   end

   // velocity jog swaps in its gain pair
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         loop_p_gain <= 16'h0000;
         loop_i_gain <= 16'h0000;
      end
      else if (ce)
      begin
         loop_p_gain <= (mode_reg == jsg_pkg::JSG_MODE_VEL) ? vel_p_reg
                                                             : pos_p_gain;
         loop_i_gain <= (mode_reg == jsg_pkg::JSG_MODE_VEL) ? vel_i_reg
                                                             : pos_i_gain;
      end
   end

   // ------------------------------------------------------------
   // AXI read channel
   // ------------------------------------------------------------
   // reads return stored values
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         rresp_reg   <= jsg_pkg::JSG_RESP_OKAY;
      end
      else if (ce)
      begin
         if (arvalid && arready_reg)
         begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rresp_reg   <= jsg_pkg::JSG_RESP_OKAY;
            unique case (araddr)
               `JSG_OFS_ACCEL:  rdata_reg <= {16'h0000, accel_reg};
               `JSG_OFS_DECEL:  rdata_reg <= {16'h0000, decel_reg};
               `JSG_OFS_MODE:   rdata_reg <= {23'h000000, trq_reg,
                                              6'h00, mode_reg};
               `JSG_OFS_SPEED:  rdata_reg <= {16'h0000, speed_reg};
               `JSG_OFS_LFILT:  rdata_reg <= {16'h0000, lfilt_reg};
               `JSG_OFS_DGAIN:  rdata_reg <= {16'h0000, dgain_reg};
               `JSG_OFS_DFILT:  rdata_reg <= {16'h0000, dfilt_reg};
               `JSG_OFS_VFF:    rdata_reg <= {16'h0000, vff_reg};
               `JSG_OFS_VFB:    rdata_reg <= {16'h0000, vfb_reg};
               `JSG_OFS_PFLIM:  rdata_reg <= {16'h0000, pflim_reg};
               `JSG_OFS_VIGAIN: rdata_reg <= {16'h0000, vel_i_reg};
               `JSG_OFS_VPGAIN: rdata_reg <= {16'h0000, vel_p_reg};
               `JSG_OFS_STATUS: rdata_reg <= {28'h0000000, STEPPER,
                                              rej_reg, fault_reg,
                                              jog_active};
               `JSG_OFS_SPD026: rdata_reg <= {14'h0000, speed_reg,
                                              2'h0};
               default:
               begin
                  rdata_reg <= 32'h0000_0000;
                  rresp_reg <= jsg_pkg::JSG_RESP_SLVERR;
               end
            endcase
         end
         else if (rvalid_reg && rready)
         begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // decel register feeds every jog stop
   assign jog_decel    = decel_reg;
   assign jog_accel    = accel_reg;
   assign jog_speed    = speed_reg;
   assign jog_mode_vel = mode_reg[1]; // Only code 2 has bit 1 set
   assign torque_sel   = trq_reg;
   assign loop_filter  = lfilt_reg;
   assign deriv_gain   = dgain_reg;
   assign deriv_filter = dfilt_reg;
   assign vff_gain     = vff_reg;
   assign vfb_gain     = vfb_reg;
   assign jog_fault    = fault_reg;
   assign target_pos   = target_reg;
   assign awready      = awready_reg;
   assign wready       = wready_reg;
   assign bvalid       = bvalid_reg;
   assign bresp        = bresp_reg;
   assign arready      = arready_reg;
   assign rvalid       = rvalid_reg;
   assign rdata        = rdata_reg;
   assign rresp        = rresp_reg;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   decel_lock_a: assert property (jog_active && $past(jog_active)
      |-> $stable(decel_reg))
      else $error("decel changed during jog");
   accel_copy_a: assert property (wr_hit && aw_addr_reg == `JSG_OFS_ACCEL
      |=> decel_reg == accel_reg)
      else $error("accel write did not copy to decel");
   rate_range_a: assert property (decel_reg >= `JSG_RATE_MIN
      && decel_reg <= `JSG_RATE_MAX)
      else $error("decel out of range");
   mode_code_a: assert property (mode_reg == jsg_pkg::JSG_MODE_POS
      || (!STEPPER && mode_reg == jsg_pkg::JSG_MODE_VEL))
      else $error("illegal jog mode");
   fault_vel_a: assert property (mode_reg == jsg_pkg::JSG_MODE_VEL
      && $past(mode_reg) == jsg_pkg::JSG_MODE_VEL
      |-> !jog_fault)
      else $error("fault raised in velocity jog");
   fault_set_a: assert property (ce && jog_active && !STEPPER
      && mode_reg == jsg_pkg::JSG_MODE_POS && err_mag > {16'h0000, pflim_reg}
      |=> jog_fault)
      else $error("position fault missed");
   speed_read_a: assert property (arvalid && arready && ce
      && araddr == `JSG_OFS_SPEED
      |=> rvalid && rdata[15:0] == $past(speed_reg))
      else $error("speed read mismatch");
   reject_keep_a: assert property (wr_fire && !wr_ok
      |=> $stable(speed_reg) && $stable(lfilt_reg) && bvalid
      && bresp == jsg_pkg::JSG_RESP_SLVERR)
      else $error("rejected write changed state");
   gain_range_a: assert property (dgain_reg <= `JSG_INT_MAX
      && vff_reg <= `JSG_INT_MAX && dfilt_reg <= `JSG_INT_MAX)
      else $error("gain out of range");
   vel_gain_a: assert property (ce && mode_reg == jsg_pkg::JSG_MODE_VEL
      |=> loop_p_gain == $past(vel_p_reg))
      else $error("velocity gains not selected");

   write_c: cover property (wr_hit && aw_addr_reg == `JSG_OFS_DECEL);
   reject_c: cover property (wr_fire && !wr_ok && jog_active);
   fault_c: cover property (jog_fault);
   vel_c: cover property (jog_mode_vel && jog_active);

endmodule

// >>> jsg_defines.svh
`ifndef JSG_DEFINES_SVH
`define JSG_DEFINES_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define JSG_OFS_ACCEL     8'h00
`define JSG_OFS_DECEL     8'h04
`define JSG_OFS_MODE      8'h08
`define JSG_OFS_SPEED     8'h0C
`define JSG_OFS_LFILT     8'h10
`define JSG_OFS_DGAIN     8'h14
`define JSG_OFS_DFILT     8'h18
`define JSG_OFS_VFF       8'h1C
`define JSG_OFS_VFB       8'h20
`define JSG_OFS_PFLIM     8'h24
`define JSG_OFS_VIGAIN    8'h28
`define JSG_OFS_VPGAIN    8'h2C
`define JSG_OFS_STATUS    8'h30
`define JSG_OFS_SPD026    8'h34

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define JSG_MODE_TRQ_BIT  8
`define JSG_ST_JOG_BIT    0
`define JSG_ST_FAULT_BIT  1
`define JSG_ST_REJ_BIT    2
`define JSG_ST_STEP_BIT   3
`define JSG_SPD026_SHIFT  2

// ------------------------------------------------------------
// Ranges in steps (0.167 rps/s, 0.0042 rps, integer)
// ------------------------------------------------------------
`define JSG_RATE_MIN      16'h0001
`define JSG_RATE_MAX      16'h7FBD
`define JSG_SPD_MIN       16'h0001
`define JSG_SPD_MAX       16'h7C02
`define JSG_SPD_MAX_SMALL 16'h4A67
`define JSG_INT_MAX       16'h7FFF

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define JSG_RST_RATE      16'h0258
`define JSG_RST_SPEED     16'h0960
`define JSG_RST_GAIN      16'h0000

`endif

// >>> jsg_pkg.sv
package jsg_pkg;

   // Jog mode codes
   typedef enum logic [1:0]
   {
      JSG_MODE_POS = 2'h1,
      JSG_MODE_VEL = 2'h2
   } jsg_mode_e;

   // AXI response codes
   typedef enum logic [1:0]
   {
      JSG_RESP_OKAY   = 2'h0,
      JSG_RESP_SLVERR = 2'h2
   } jsg_resp_e;

   // Parameter word
   typedef logic [15:0] jsg_word_t;

endpackage

// >>> jsg_motion_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Motion loop stand-in
// ------------------------------------------------------------
module jsg_motion_model
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Jog request from the bench
   input  wire logic        run,
   // Status toward the block
   output logic             jog_active,
   output logic             jog_tick,
   output logic [15:0]      pos_p_gain,
   output logic [15:0]      pos_i_gain
);
   logic [1:0] div_reg;
   // Position gains held outside the block
   assign pos_p_gain = 16'h0123;
   assign pos_i_gain = 16'h0456;
   // Jog follows the request, one step every fourth cycle
   always_ff @(posedge aclk)
   begin
      jog_active <= aresetn && run;
      div_reg    <= jog_active ? div_reg + 2'h1 : 2'h0;
      jog_tick   <= aresetn && run && jog_active && div_reg == 2'h3;
   end
endmodule

// >>> tb.sv
`timescale 1ns/1ns
module tb;
   // ---------------------------------------------------------
   // Signals
   // ---------------------------------------------------------
   logic        aclk, aresetn, run, awvalid, wvalid, bready, arvalid;
   logic        rready, awready, wready, bvalid, arready, rvalid, ce, dir;
   logic        jog_active, jog_tick, jog_mode_vel, torque_sel, jog_fault;
   logic [1:0]  bresp, rresp, rs;
   logic [3:0]  wstrb;
   logic [7:0]  awaddr, araddr;
   logic [15:0] jog_accel, jog_decel, jog_speed, loop_filter, deriv_gain;
   logic [15:0] deriv_filter, vff_gain, vfb_gain, pos_p_gain, pos_i_gain;
   logic [15:0] loop_p_gain, loop_i_gain;
   logic [15:0] mem [12];
   logic [31:0] wdata, rdata, pos_error, target_pos, t0, rd, cnt;
   int          n_errors, num_checks, k;

   // ---------------------------------------------------------
   // Block, motion loop and clock
   // ---------------------------------------------------------
   jsg_params uut
   (
      .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .jog_active,
      .jog_tick, .jog_dir(dir), .pos_error, .pos_p_gain, .pos_i_gain,
      .jog_accel, .jog_decel, .jog_speed, .jog_mode_vel, .torque_sel,
      .loop_filter, .deriv_gain, .deriv_filter, .vff_gain, .vfb_gain,
      .loop_p_gain, .loop_i_gain, .jog_fault, .target_pos
   );
   jsg_motion_model pm
   (
      .aclk, .aresetn, .run, .jog_active, .jog_tick, .pos_p_gain,
      .pos_i_gain
   );
   always #5 aclk = ~aclk;
   // Steps seen by the block
   always @(posedge aclk)
      if (jog_tick && ce) cnt <= cnt + 1;

   // ---------------------------------------------------------
   // Checks and bus tasks
   // ---------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   // Write: address and data offered together
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
      bit done;
      done = 0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1;
      wvalid  <= 1;
      bready  <= 1;
      while (!done)
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bvalid && bready)
         begin
            r = bresp;
            bready <= 0;
            done = 1;
         end
      end
   endtask
   // Read one word
   task automatic axr(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
      bit done;
      done = 0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1;
      rready  <= 1;
      while (!done)
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 0;
         if (rvalid && rready)
         begin
            d = rdata;
            r = rresp;
            rready <= 0;
            done = 1;
         end
      end
   endtask
   task automatic wc(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e);
      axw(a, d, rs);
      chk("bresp", e, rs);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      axr(a, rd, rs);
      chk("rdata", e, rd);
   endtask

   // ---------------------------------------------------------
   // Expectations
   // ---------------------------------------------------------
   function automatic logic [15:0] vmax(int i);
      if (i < 2) return 16'h7FBD;
      if (i == 3) return 16'h7C02;
      return 16'h7FFF;
   endfunction
   function automatic logic [15:0] vmin(int i);
      return (i < 2 || i == 3) ? 16'h0001 : 16'h0000;
   endfunction
   // Response and stored values after a write
   function automatic logic [1:0] upd(int i, logic [15:0] x);
      if (x < vmin(i) || x > vmax(i)) return 2'h2;
      mem[i] = x;
      if (i == 0) mem[1] = x;
      return 2'h0;
   endfunction
   function automatic logic [15:0] outv(int i);
      case (i)
         0: return jog_accel;
         1: return jog_decel;
         3: return jog_speed;
         4: return loop_filter;
         5: return deriv_gain;
         6: return deriv_filter;
         7: return vff_gain;
         8: return vfb_gain;
         default: return mem[i];
      endcase
   endfunction
   // Host filter value for a cutoff in Hz, rounded
   function automatic logic [15:0] filt(int f);
      return 16'((720900 * f + 7000 + 11 * f) / (14000 + 22 * f));
   endfunction
   // Write one register, then check readback, decel and port
   task automatic wt(int i, logic [15:0] x);
      wc(8'(i * 4), {16'h0, x}, upd(i, x));
      rc(8'(i * 4), {16'h0, mem[i]});
      rc(8'h04, {16'h0, mem[1]});
      chk("port", mem[i], outv(i));
   endtask
   task automatic end_sim();
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ---------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------
   initial
   begin
      {aclk, aresetn, run, awvalid, wvalid, bready, arvalid, rready} = 0;
      {awaddr, araddr, wdata, pos_error, cnt} = 0;
      wstrb = 4'hF;
      ce = 1'b1;
      dir = 1'b0;
      foreach (mem[i]) mem[i] = 16'h0;
      {mem[0], mem[1], mem[2], mem[3]} = 64'h0258_0258_0001_0960;
      void'($urandom(86572));
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      for (k = 0; k < 12; k++) rc(8'(k * 4), {16'h0, mem[k]});
      rc(8'h34, 32'h2580);
      for (k = 0; k < 12; k++)
      begin
         if (k == 2) continue;
         if (vmin(k) > 0) wt(k, vmin(k) - 16'h1);
         wt(k, vmin(k));
         wt(k, vmax(k));
         wt(k, vmax(k) + 16'h1);
      end
      repeat (40)
      begin
         k = $urandom_range(11);
         if (k == 2) k = 1;
         wt(k, 16'($urandom_range(32'h8002)));
      end
      wt(0, 16'h0100);
      wt(1, 16'h0040);
      rc(8'h00, 32'h0100);
      rc(8'h34, {14'h0, mem[3], 2'h0});
      wt(4, filt(200));
      wt(6, filt(200));
      wt(8, 16'h0FA0);
      wt(7, mem[8]);
      // Refused accesses leave state alone
      wstrb <= 4'h3;
      wc(8'h14, 32'h5, 2'h2);
      wstrb <= 4'hF;
      wc(8'h34, 32'h1, 2'h2);
      axr(8'h38, rd, rs);
      chk("rresp", 2'h2, rs);
      chk("rdata", 32'h0, rd);
      rc(8'h14, {16'h0, mem[5]});
      axr(8'h30, rd, rs);
      chk("reject", 1'b1, rd[2]);
      wc(8'h30, 32'h4, 2'h0);
      axr(8'h30, rd, rs);
      chk("clear", 1'b0, rd[2]);
      // Jog modes and gain selection
      wt(11, 16'h0321);
      wt(10, 16'h0654);
      wc(8'h08, 32'h2, 2'h0);
      repeat (2) @(posedge aclk);
      chk("vel", 1'b1, jog_mode_vel);
      chk("kp", mem[11], loop_p_gain);
      chk("ki", mem[10], loop_i_gain);
      wc(8'h08, 32'h3, 2'h2);
      wc(8'h08, 32'h0, 2'h2);
      rc(8'h08, 32'h2);
      wc(8'h08, 32'h102, 2'h0);
      repeat (2) @(posedge aclk);
      chk("torque", 1'b1, torque_sel);
      wc(8'h08, 32'h1, 2'h0);
      repeat (2) @(posedge aclk);
      chk("torque", 1'b0, torque_sel);
      chk("kp", 16'h0123, loop_p_gain);
      // Position jog: decel locked, target advances
      t0 = target_pos;
      run <= 1;
      repeat (2) @(posedge aclk);
      wc(8'h04, 32'h10, 2'h2);
      wc(8'h00, 32'h10, 2'h2);
      rc(8'h04, {16'h0, mem[1]});
      chk("decel", mem[1], jog_decel);
      repeat (20) @(posedge aclk);
      run <= 0;
      repeat (4) @(posedge aclk);
      chk("target", t0 + cnt * mem[3], target_pos);
      // Fault limit only in position jog
      wt(9, 16'h0064);
      wc(8'h08, 32'h2, 2'h0);
      pos_error <= 32'h0000_0065;
      run <= 1;
      repeat (6) @(posedge aclk);
      chk("fault", 1'b0, jog_fault);
      pos_error <= 32'h0000_0064;
      wc(8'h08, 32'h1, 2'h0);
      repeat (4) @(posedge aclk);
      chk("fault", 1'b0, jog_fault);
      pos_error <= 32'h0000_0065;
      repeat (4) @(posedge aclk);
      chk("fault", 1'b1, jog_fault);
      // Enable low freezes the target, then jog backwards
      ce <= 0;
      @(posedge aclk);
      t0 = target_pos;
      repeat (8) @(posedge aclk);
      chk("freeze", t0, target_pos);
      rd = cnt;
      dir <= 1;
      ce <= 1;
      repeat (12) @(posedge aclk);
      chk("reverse", t0 - (cnt - rd) * mem[3], target_pos);
      run <= 0;
      end_sim();
   end
   // Watchdog against a hung handshake
   initial
   begin
      #400000;
      n_errors++;
      end_sim();
   end
endmodule
